// *** hdl/ppcs_top.sv ***
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "ppcs_map.svh"
`default_nettype none
module ppcs_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic access_req,
  input wire logic access_write,
  input wire logic [1:0] lane_sel,
  input wire logic ack_line,
  output logic region_select_pin_out,
  output logic region_select_pin_oe,
  output logic lane_enable_low,
  output logic lane_enable_high,
  output logic read_line,
  output logic write_line,
  output logic ack_seen,
  output logic [1:0] port_width_select
);

  ppcs_pkg::ppcs_bus_state_type st;
  ppcs_pkg::ppcs_bus_state_type next_st;
  ppcs_pkg::ppcs_pin_type pins;
  logic addr_ok;

  // word offset match; upper address bits must be zero so read aliases stay unmapped (writes keep only haddr[7:0], so write aliases hit)
  function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] offs);
    reg_hit = (addr[31:`PPCS_ADDR_MSB + 1] == '0) && (addr[7:2] == offs[7:2]);
  endfunction

  // reserved width code keeps the old width rather than a lane pattern nobody wired
  function automatic ppcs_pkg::ppcs_cfg_type cfg_write(
      input ppcs_pkg::ppcs_cfg_type old, input logic [15:0] data);
    ppcs_pkg::ppcs_cfg_type nv;
    nv = ppcs_pkg::ppcs_cfg_type'(data & `PPCS_CFG_WMASK);
    if (nv.port_width_select == `PPCS_WIDTH_RSVD) begin
      nv.port_width_select = old.port_width_select;
    end
    cfg_write = nv;
  endfunction

  function automatic logic [31:0] read_value(
      input ppcs_pkg::ppcs_bus_state_type s, input logic [31:0] addr,
      input ppcs_pkg::ppcs_pin_type p);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (reg_hit(addr, `PPCS_CFG_OFFSET)) begin
      v[15:0] = s.cfg;
    end else if (reg_hit(addr, `PPCS_STAT_OFFSET)) begin
      v[`PPCS_STAT_ACK_BIT] = p.ack;
      v[`PPCS_STAT_ERR_BIT] = s.width_err;
      v[`PPCS_STAT_ACTIVE_BIT] = access_req & ~s.cfg.region_disable;
    end
    read_value = v;
  endfunction

  assign addr_ok = hsel & hready & htrans[1] & (hsize == `PPCS_HSIZE_WORD);

  always_comb begin
    logic [31:0] wa;
    wa = {24'h00_0000, st.wr_addr};
    next_st = st;
    next_st.wr_pend = 1'b0;
    // data phase of a write lands here
    if (st.wr_pend) begin
      if (reg_hit(wa, `PPCS_CFG_OFFSET)) begin
        next_st.cfg = cfg_write(st.cfg, hwdata[15:0]);
        if (hwdata[6:5] == `PPCS_WIDTH_RSVD) begin
          next_st.width_err = 1'b1;
        end
      end else if (reg_hit(wa, `PPCS_STAT_OFFSET) && hwdata[`PPCS_STAT_ERR_BIT]) begin
        next_st.width_err = 1'b0;
      end
    end
    // address phase; read data taken from the updated state so a
    // read right behind a write sees the new value
    if (addr_ok) begin
      if (hwrite) begin
        next_st.wr_pend = 1'b1;
        next_st.wr_addr = haddr[7:0];
      end else begin
        next_st.rdata = read_value(next_st, haddr, pins);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;

  ppcs_cfg_if link ();

  assign link.cfg = st.cfg;
  assign link.access_req = access_req;
  assign link.access_write = access_write;
  assign link.lane_sel = lane_sel;
  assign link.ack_raw = ack_line;

  ppcs_strobe u_strobe (
    .hclk(hclk),
    .hresetn(hresetn),
    .link(link.dst),
    .pins(pins)
  );

  assign region_select_pin_out = pins.cs_out;
  assign region_select_pin_oe = pins.cs_oe;
  assign lane_enable_low = pins.lane_lo;
  assign lane_enable_high = pins.lane_hi;
  assign read_line = pins.rd;
  assign write_line = pins.wr;
  assign ack_seen = pins.ack;
  assign port_width_select = pins.width;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  cs_pin_drive_a: assert property (
    1'b1 |=> region_select_pin_oe == $past(st.cfg.cs_pin_enable))
    else $error("region select enable does not follow config");

  cs_pin_write_a: assert property (
    st.wr_pend && reg_hit({24'h00_0000, st.wr_addr}, `PPCS_CFG_OFFSET)
    |=> ##1 region_select_pin_oe == $past(hwdata[13], 2))
    else $error("written pin enable not on the pin two cycles later");

  lane_polarity_a: assert property (
    access_req && !st.cfg.region_disable && lane_sel == 2'h3
    |=> lane_enable_low == $past(st.cfg.byte_enable_polarity)
        && lane_enable_high == lane_enable_low)
    else $error("lane enables not at configured active level");

  lane_idle_a: assert property (
    !access_req |=> lane_enable_low != $past(st.cfg.byte_enable_polarity)
                    && lane_enable_high == lane_enable_low)
    else $error("idle lane enables not at inactive level");

  write_strobe_a: assert property (
    !st.cfg.strobe_style_select && access_req && access_write && !st.cfg.region_disable
    |=> write_line == $past(st.cfg.write_strobe_polarity)
        && read_line != $past(st.cfg.read_strobe_polarity))
    else $error("separate write strobe level wrong");

  enable_strobe_a: assert property (
    st.cfg.strobe_style_select && access_req && !st.cfg.region_disable
    |=> write_line == $past(st.cfg.write_strobe_polarity))
    else $error("enable strobe level wrong");

  read_strobe_a: assert property (
    !st.cfg.strobe_style_select && access_req && !access_write && !st.cfg.region_disable
    |=> read_line == $past(st.cfg.read_strobe_polarity)
        && write_line != $past(st.cfg.write_strobe_polarity))
    else $error("separate read strobe level wrong");

  direction_line_a: assert property (
    st.cfg.strobe_style_select
    |=> read_line == ($past(st.cfg.read_strobe_polarity) ^ $past(access_write)))
    else $error("direction line level wrong");

  combined_idle_a: assert property (
    st.cfg.strobe_style_select && !access_req
    |=> write_line != $past(st.cfg.write_strobe_polarity))
    else $error("enable strobe active outside an access");

  separate_idle_a: assert property (
    !st.cfg.strobe_style_select && !access_req
    |=> read_line != $past(st.cfg.read_strobe_polarity)
        && write_line != $past(st.cfg.write_strobe_polarity))
    else $error("separate strobes active outside an access");

  width_code_a: assert property (
    st.wr_pend && reg_hit({24'h00_0000, st.wr_addr}, `PPCS_CFG_OFFSET)
    && hwdata[6:5] == `PPCS_WIDTH_RSVD
    |=> st.width_err && st.cfg.port_width_select == $past(st.cfg.port_width_select)
        ##1 port_width_select != `PPCS_WIDTH_RSVD)
    else $error("reserved width code was taken");

  bus_ready_a: assert property (
    hreadyout && !hresp)
    else $error("slave must be zero-wait OKAY");

  // software polls status between reads, so a drifting hrdata would be misread
  hrdata_hold_a: assert property (
    !(addr_ok && !hwrite) |=> $stable(hrdata))
    else $error("read data changed outside a read");

  region_off_a: assert property (
    access_req && st.cfg.region_disable
    |=> region_select_pin_out != $past(st.cfg.cs_polarity)
        && lane_enable_low != $past(st.cfg.byte_enable_polarity)
        && write_line != $past(st.cfg.write_strobe_polarity))
    else $error("disabled region still strobed");

  cs_level_a: assert property (
    access_req && !st.cfg.region_disable
    |=> region_select_pin_out == $past(st.cfg.cs_polarity))
    else $error("region select not at configured active level");

  ack_level_a: assert property (
    1'b1 |=> ack_seen == ($past(ack_line) == $past(st.cfg.ack_polarity)))
    else $error("acknowledge not normalised by its polarity");

  width_pin_a: assert property (
    1'b1 |=> port_width_select == $past(st.cfg.port_width_select))
    else $error("width code on the pin does not follow config");

endmodule // ppcs_top
`default_nettype wire

// *** hdl/ppcs_map.svh ***
`ifndef PPCS_MAP_SVH
`define PPCS_MAP_SVH

// register offsets, byte addresses within the slave window
`define PPCS_CFG_OFFSET 8'h00
`define PPCS_STAT_OFFSET 8'h04
`define PPCS_ADDR_MSB 7

// writable bits of the config register; reserved bits read zero
`define PPCS_CFG_RESET 16'h0000
`define PPCS_CFG_WMASK 16'hF7E0

// status register fields
`define PPCS_STAT_ACK_BIT 0
`define PPCS_STAT_ERR_BIT 1
`define PPCS_STAT_ACTIVE_BIT 2

// port width codes
`define PPCS_WIDTH_8 2'h0
`define PPCS_WIDTH_4 2'h1
`define PPCS_WIDTH_16 2'h2
`define PPCS_WIDTH_RSVD 2'h3

// bus constants
`define PPCS_HSIZE_WORD 3'h2

// pin state after reset: strobes idle high for the all-zero config
`define PPCS_PIN_RESET 9'h178

`endif

// *** hdl/ppcs_pkg.sv ***
package ppcs_pkg;

  typedef struct packed {
    logic region_disable;
    logic cs_polarity;
    logic cs_pin_enable;
    logic byte_enable_polarity;
    logic rsvd11;
    logic write_strobe_polarity;
    logic read_strobe_polarity;
    logic strobe_style_select;
    logic ack_polarity;
    logic [1:0] port_width_select;
    logic [4:0] rsvd4_0;
  } ppcs_cfg_type;

  typedef struct packed {
    ppcs_cfg_type cfg;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic width_err;
  } ppcs_bus_state_type;

  typedef struct packed {
    logic cs_out;
    logic cs_oe;
    logic lane_lo;
    logic lane_hi;
    logic rd;
    logic wr;
    logic ack;
    logic [1:0] width;
  } ppcs_pin_type;

endpackage

// *** hdl/ppcs_cfg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ppcs_cfg_if;
  ppcs_pkg::ppcs_cfg_type cfg;
  logic access_req;
  logic access_write;
  logic [1:0] lane_sel;
  logic ack_raw;

  modport src (
    output cfg,
    output access_req,
    output access_write,
    output lane_sel,
    output ack_raw
  );

  modport dst (
    input cfg,
    input access_req,
    input access_write,
    input lane_sel,
    input ack_raw
  );
endinterface
`default_nettype wire

// *** hdl/ppcs_strobe.sv ***
`timescale 1ns/1ps
`include "ppcs_map.svh"
`default_nettype none
module ppcs_strobe (
  input wire logic hclk,
  input wire logic hresetn,
  ppcs_cfg_if.dst link,
  output ppcs_pkg::ppcs_pin_type pins
);

  ppcs_pkg::ppcs_pin_type st;
  ppcs_pkg::ppcs_pin_type next_st;

  // level on a pin for an asserted/negated function under a polarity bit
  function automatic logic drive_level(input logic assert_it, input logic pol);
    drive_level = pol ? assert_it : ~assert_it;
  endfunction

  always_comb begin
    logic active;
    active = link.access_req & ~link.cfg.region_disable;
    next_st = st;
    next_st.cs_oe = link.cfg.cs_pin_enable;
    next_st.cs_out = drive_level(active, link.cfg.cs_polarity);
    next_st.lane_lo = drive_level(active & link.lane_sel[0],
                                  link.cfg.byte_enable_polarity);
    next_st.lane_hi = drive_level(active & link.lane_sel[1],
                                  link.cfg.byte_enable_polarity);
    if (link.cfg.strobe_style_select) begin
      // combined: read pin is direction (asserted = read), write pin is enable
      next_st.rd = drive_level(~link.access_write,
                               link.cfg.read_strobe_polarity);
      next_st.wr = drive_level(active, link.cfg.write_strobe_polarity);
    end else begin
      // same polarity meaning whether the far end is master or slave
      next_st.rd = drive_level(active & ~link.access_write,
                               link.cfg.read_strobe_polarity);
      next_st.wr = drive_level(active & link.access_write,
                               link.cfg.write_strobe_polarity);
    end
    next_st.ack = drive_level(link.ack_raw, link.cfg.ack_polarity);
    next_st.width = link.cfg.port_width_select;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= `PPCS_PIN_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign pins = st;

endmodule // ppcs_strobe
`default_nettype wire

// *** sim/ppcs_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppcs_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic read_line,
  input wire logic write_line,
  input wire logic rd_pol,
  input wire logic wr_pol,
  input wire logic ack_pol,
  input wire logic [2:0] delay,
  output logic ack_line
);
  logic [2:0] cnt;
  logic strobed;
  // same strobe levels in slave and separate-strobe master use
  assign strobed = (read_line == rd_pol) || (write_line == wr_pol);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 3'h0;
    end else if (!strobed) begin
      cnt <= 3'h0;
    end else if (cnt != 3'h7) begin
      cnt <= cnt + 3'h1;
    end
  end
  // a slow device holds ack off for delay cycles
  assign ack_line = (strobed && cnt >= delay) ? ack_pol : ~ack_pol;
endmodule // ppcs_partner
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`include "ppcs_map.svh"
`default_nettype none
module testbench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, access_req, access_write, ack_line;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, lane_sel, width;
  logic [2:0] hsize, ack_delay;
  logic cs_out, cs_oe, lane_lo, lane_hi, read_line, write_line, ack_seen;
  logic rd_pol, wr_pol, ack_pol;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  ppcs_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .access_req(access_req), .access_write(access_write),
    .lane_sel(lane_sel), .ack_line(ack_line), .region_select_pin_out(cs_out),
    .region_select_pin_oe(cs_oe), .lane_enable_low(lane_lo), .lane_enable_high(lane_hi),
    .read_line(read_line), .write_line(write_line), .ack_seen(ack_seen),
    .port_width_select(width));

  ppcs_partner partner (.hclk(hclk), .hresetn(hresetn), .read_line(read_line),
    .write_line(write_line), .rd_pol(rd_pol), .wr_pol(wr_pol), .ack_pol(ack_pol),
    .delay(ack_delay), .ack_line(ack_line));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task give_verdict;
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  // waits on hready instead of assuming zero wait
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'h2; hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0, "response not OKAY");
  endtask

  function automatic logic [31:0] cfg(input logic dis, sel_pol, sel_en, lane_pol, wr_lvl,
      rd_lvl, combined, ack_lvl, input logic [1:0] w);
    cfg = {16'h0000, dis, sel_pol, sel_en, lane_pol, 1'b0, wr_lvl, rd_lvl, combined, ack_lvl, w,
      5'h00};
  endfunction

  task setcfg(input logic [31:0] v);
    ahb(1'b1, 32'h0, v);
    rd_pol <= v[9]; wr_pol <= v[10]; ack_pol <= v[7];
  endtask

  task access(input logic wr, input logic [1:0] lanes, input logic req);
    @(posedge hclk);
    access_req <= req; access_write <= wr; lane_sel <= lanes;
    @(posedge hclk);
    @(posedge hclk);
    #1;
  endtask

  task t_regs;
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0, "config reset");
    ahb(1'b1, 32'h0, 32'hFFFF_FFBF);
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, {16'h0000, 16'hFFBF & `PPCS_CFG_WMASK}, "config readback");
    ahb(1'b0, 32'h80, 32'h0);
    chk(rd, 32'h0, "unmapped read");
  endtask

  task t_width;
    for (int w = 0; w < 3; w++) begin
      setcfg(cfg(0, 0, 1, 0, 0, 0, 0, 0, w[1:0]));
      access(1'b0, 2'h0, 1'b0);
      chk(width, w, "width code");
    end
    setcfg(cfg(0, 0, 1, 0, 0, 0, 0, 0, 2'h3));
    access(1'b0, 2'h0, 1'b0);
    chk(width, 32'h2, "reserved width taken");
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd[1], 1'b1, "width error flag");
    ahb(1'b1, 32'h4, 32'h2);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd[1], 1'b0, "width error cleared");
  endtask

  task t_strobes;
    logic lane_pol, wr_lvl, rd_lvl, combined, sel_pol, rl, wl;
    for (int m = 0; m < 16; m++) begin
      {combined, rd_lvl, wr_lvl, lane_pol} = m[3:0];
      sel_pol = wr_lvl ^ rd_lvl;
      setcfg(cfg(0, sel_pol, 1, lane_pol, wr_lvl, rd_lvl, combined, 0, 2'h2));
      for (int wr = 0; wr < 2; wr++) begin
        access(wr[0], 2'h1, 1'b1);
        rl = wr[0] ? ~rd_lvl : rd_lvl;
        wl = (combined || wr[0]) ? wr_lvl : ~wr_lvl;
        chk({cs_oe, cs_out, lane_lo, lane_hi, read_line, write_line},
          {1'b1, sel_pol, lane_pol, ~lane_pol, rl, wl}, "active strobes");
        access(1'b0, 2'h3, 1'b0);
        chk({cs_out, lane_lo, lane_hi, write_line},
          {~sel_pol, ~lane_pol, ~lane_pol, ~wr_lvl}, "idle");
        if (!combined) chk(read_line, !rd_lvl, "idle read strobe");
      end
    end
    setcfg(cfg(0, 0, 0, 0, 0, 0, 0, 0, 2'h2));
    access(1'b0, 2'h3, 1'b1);
    chk(cs_oe, 1'b0, "select pin released");
    setcfg(cfg(1, 0, 1, 0, 0, 0, 0, 0, 2'h2));
    access(1'b0, 2'h3, 1'b1);
    chk({cs_out, lane_lo, lane_hi, read_line, write_line}, 5'h1F, "disabled region");
  endtask

  // prompt and slow device, both ack polarities
  task t_ack;
    for (int k = 0; k < 4; k++) begin
      ack_delay <= k[1] ? 3'h3 : 3'h0;
      setcfg(cfg(0, 0, 1, 0, 0, 0, 0, k[0], 2'h2));
      access(1'b0, 2'h1, 1'b1);
      chk(ack_seen, !k[1], "ack timing");
      repeat (4) @(posedge hclk);
      #1;
      chk(ack_seen, 1'b1, "ack seen");
      ahb(1'b0, 32'h4, 32'h0);
      chk(rd[2:0], 3'h5, "status ack and active");
      access(1'b0, 2'h1, 1'b0);
      chk(ack_seen, 1'b0, "ack dropped");
    end
  endtask

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; access_req = 1'b0; access_write = 1'b0; lane_sel = 2'h0;
    rd_pol = 1'b0; wr_pol = 1'b0; ack_pol = 1'b0; ack_delay = 3'h0;
    repeat (8) @(posedge hclk);
    #1;
    chk({cs_oe, cs_out, lane_lo, lane_hi, read_line, write_line, ack_seen, width},
      9'h0F8, "pins in reset");
    @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_width;
    t_strobes;
    t_ack;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
